/* File: core/psbs_consts.vh */
// Purpose: Constants for the parallel slave buffer status block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Included by psbs_status.v
`ifndef PSBS_CONSTS_VH
`define PSBS_CONSTS_VH

// Register byte offsets
`define PSBS_OFS_STATUS   8'h00
`define PSBS_OFS_CTRL     8'h04
`define PSBS_OFS_INT_STAT 8'h08
`define PSBS_OFS_INT_EN   8'h0C
`define PSBS_OFS_INT_CLR  8'h10
`define PSBS_OFS_IN_BUF   8'h20
`define PSBS_OFS_OUT_BUF  8'h30
`define PSBS_BUF_MASK     8'hF3

// Status field positions
`define PSBS_BIT_IN_ALL_FULL   15
`define PSBS_BIT_IN_OVERFLOW   14
`define PSBS_POS_IN_FULL       8
`define PSBS_BIT_OUT_ALL_EMPTY 7
`define PSBS_BIT_OUT_UNDERFLOW 6
`define PSBS_POS_OUT_EMPTY     0

// Control field positions
`define PSBS_BIT_SLAVE_MODE 0

// Interrupt event positions
`define PSBS_EV_HOST_WROTE 0
`define PSBS_EV_HOST_READ  1
`define PSBS_EV_OVERFLOW   2
`define PSBS_EV_UNDERFLOW  3

// Reset values
`define PSBS_RST_IN_FULL   4'h0
`define PSBS_RST_OUT_EMPTY 4'hF
`define PSBS_RST_CTRL      1'h0
`define PSBS_RST_INT       4'h0
`define PSBS_RST_ERR       1'h0

// AXI responses
`define PSBS_RESP_OKAY   2'h0
`define PSBS_RESP_SLVERR 2'h2

`endif

/* File: core/psbs_status.v */
// Purpose: Buffer status tracking for the slave side of a parallel port
// Assumes: Host strobes are asynchronous levels; index and data held stable around them
// Notes:   Four input and four output byte buffers, status and interrupts over AXI4-Lite
// Behaviour
// - Status flags meaningful only in slave mode
// - Input all-full high when every buffer full
// - Host write to full buffer sets overflow
// - Per-buffer full flag, software read clears
// - Output all-empty high when every buffer empty
// - Host read of empty buffer sets underflow
// - Per-buffer empty flag, software write clears
// - Unused status bits read as zero
// - Error flags cleared only by explicit write
`timescale 1ns/1ps
`default_nettype none
`include "psbs_consts.vh"

module psbs_status #(
   parameter NBUF = 4,
   parameter DW   = 8
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // External host write strobe
   input  wire        host_wr_req,
   input  wire [1:0]  host_wr_idx,
   input  wire [7:0]  host_wr_data,
   // External host read strobe
   input  wire        host_rd_req,
   input  wire [1:0]  host_rd_idx,
   output wire [7:0]  host_rd_data,
   // Interrupt
   output wire        irq
);

   function [3:0] dec4;
      input [1:0] idx;
      begin
         dec4 = 4'h1 << idx;
      end
   endfunction

   // Word-aligned hit in a four-register buffer window
   function buf_hit;
      input [7:0] addr;
      input [7:0] base;
      begin
         buf_hit = ((addr & `PSBS_BUF_MASK) == base);
      end
   endfunction

   // Host pin synchronisers
   reg         wr_req_s0_ff, wr_req_s1_ff;
   reg         wr_req_d_ff;
   reg  [1:0]  wr_idx_s0_ff, wr_idx_s1_ff;
   reg  [7:0]  wr_dat_s0_ff, wr_dat_s1_ff;
   reg         rd_req_s0_ff, rd_req_s1_ff, rd_req_d_ff;
   reg  [1:0]  rd_idx_s0_ff, rd_idx_s1_ff;

   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_req_s0_ff <= 1'b0;
         wr_req_s1_ff <= 1'b0;
         wr_req_d_ff  <= 1'b0;
         wr_idx_s0_ff <= 2'h0;
         wr_idx_s1_ff <= 2'h0;
         wr_dat_s0_ff <= 8'h00;
         wr_dat_s1_ff <= 8'h00;
         rd_req_s0_ff <= 1'b0;
         rd_req_s1_ff <= 1'b0;
         rd_req_d_ff  <= 1'b0;
         rd_idx_s0_ff <= 2'h0;
         rd_idx_s1_ff <= 2'h0;
      end else begin
         wr_req_s0_ff <= host_wr_req;
         wr_req_s1_ff <= wr_req_s0_ff;
         wr_req_d_ff  <= wr_req_s1_ff;
         wr_idx_s0_ff <= host_wr_idx;
         wr_idx_s1_ff <= wr_idx_s0_ff;
         wr_dat_s0_ff <= host_wr_data;
         wr_dat_s1_ff <= wr_dat_s0_ff;
         rd_req_s0_ff <= host_rd_req;
         rd_req_s1_ff <= rd_req_s0_ff;
         rd_req_d_ff  <= rd_req_s1_ff;
         rd_idx_s0_ff <= host_rd_idx;
         rd_idx_s1_ff <= rd_idx_s0_ff;
      end
   end

   // Registers
   reg         slave_mode_ff;
   reg  [3:0]  in_full_ff, out_empty_ff;
   reg         in_ovf_ff, out_udf_ff;
   reg  [3:0]  int_stat_ff, int_en_ff;
   reg  [7:0]  in_buf_ff [0:3];
   reg  [7:0]  out_buf_ff [0:3];
   reg  [7:0]  host_rd_data_ff;

   // Host events, honoured only in slave mode
   wire        host_wr = slave_mode_ff & wr_req_s1_ff & ~wr_req_d_ff;
   wire        host_rd = slave_mode_ff & rd_req_s1_ff & ~rd_req_d_ff;
   wire [3:0]  host_wr_sel = host_wr ? dec4(wr_idx_s1_ff) : 4'h0;
   wire [3:0]  host_rd_sel = host_rd ? dec4(rd_idx_s1_ff) : 4'h0;

   // AXI write channel
   reg         aw_got_ff, w_got_ff, bvalid_ff;
   reg  [1:0]  bresp_ff;
   reg  [7:0]  awaddr_ff;
   reg  [31:0] wdata_ff;
   reg  [3:0]  wstrb_ff;

   wire        aw_hs = s_axi_awvalid & s_axi_awready;
   wire        w_hs  = s_axi_wvalid & s_axi_wready;
   wire        aw_have = aw_got_ff | aw_hs;
   wire        w_have  = w_got_ff | w_hs;
   wire        do_wr = aw_have & w_have;
   wire [7:0]  wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
   wire [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata;
   wire [3:0]  ws = w_got_ff ? wstrb_ff : s_axi_wstrb;

   assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
   assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   wire        wr_status = do_wr & (wa == `PSBS_OFS_STATUS);
   wire        wr_ctrl   = do_wr & (wa == `PSBS_OFS_CTRL);
   wire        wr_int_en = do_wr & (wa == `PSBS_OFS_INT_EN);
   wire        wr_int_clr = do_wr & (wa == `PSBS_OFS_INT_CLR);
   wire        wr_outbuf = do_wr & buf_hit(wa, `PSBS_OFS_OUT_BUF);
   wire        wr_ok = wr_status | wr_ctrl | wr_int_en | wr_int_clr | wr_outbuf |
                       (do_wr & (wa == `PSBS_OFS_INT_STAT));
   wire [3:0]  sw_wr_sel = (wr_outbuf & ws[0]) ? dec4(wa[3:2]) : 4'h0;

   // Error flags cleared by writing zero to their bit
   wire        clr_ovf = wr_status & ws[1] & ~wd[`PSBS_BIT_IN_OVERFLOW];
   wire        clr_udf = wr_status & ws[0] & ~wd[`PSBS_BIT_OUT_UNDERFLOW];

   // AXI read channel
   reg         rvalid_ff;
   reg  [1:0]  rresp_ff;
   reg  [31:0] rdata_ff;
   wire        ar_hs = s_axi_arvalid & s_axi_arready;
   wire        rd_inbuf = ar_hs & buf_hit(s_axi_araddr, `PSBS_OFS_IN_BUF);
   wire [3:0]  sw_rd_sel = rd_inbuf ? dec4(s_axi_araddr[3:2]) : 4'h0;

   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   // Buffer flag updates; a host set wins over a software clear
   wire [3:0]  ovf_hit = host_wr_sel & in_full_ff & ~sw_rd_sel;
   wire [3:0]  in_take = host_wr_sel & ~ovf_hit;
   wire [3:0]  udf_hit = host_rd_sel & out_empty_ff & ~sw_wr_sel;
   wire [3:0]  nxt_in_full = (in_full_ff & ~sw_rd_sel) | in_take;
   wire [3:0]  nxt_out_empty = (out_empty_ff & ~sw_wr_sel) | host_rd_sel;
   wire        nxt_in_ovf = (in_ovf_ff & ~clr_ovf) | (|ovf_hit);
   wire        nxt_out_udf = (out_udf_ff & ~clr_udf) | (|udf_hit);

   // Aggregate flags
   wire        input_all_full   = &in_full_ff;
   wire        output_all_empty = &out_empty_ff;

   // Status word, zero outside slave mode and in unused bits
   wire [31:0] status_word = slave_mode_ff ?
               {16'h0000, input_all_full, in_ovf_ff, 2'b00, in_full_ff,
                output_all_empty, out_udf_ff, 2'b00, out_empty_ff} : 32'h00000000;

   // Interrupt events
   wire [3:0]  int_ev = {|udf_hit, |ovf_hit, |host_rd_sel, |in_take};
   wire [3:0]  int_clr = wr_int_clr ? wd[3:0] : 4'h0;
   wire [3:0]  nxt_int_stat = (int_stat_ff & ~int_clr) | int_ev;
   assign irq = |(int_stat_ff & int_en_ff);

   assign host_rd_data = host_rd_data_ff;

   // Read decode
   reg  [31:0] nxt_rdata;
   reg  [1:0]  nxt_rresp;
   always @* begin
      nxt_rresp = `PSBS_RESP_OKAY;
      nxt_rdata = 32'h00000000;
      case (s_axi_araddr)
         `PSBS_OFS_STATUS:   nxt_rdata = status_word;
         `PSBS_OFS_CTRL:     nxt_rdata = {31'h00000000, slave_mode_ff};
         `PSBS_OFS_INT_STAT: nxt_rdata = {28'h0000000, int_stat_ff};
         `PSBS_OFS_INT_EN:   nxt_rdata = {28'h0000000, int_en_ff};
         `PSBS_OFS_INT_CLR:  nxt_rdata = 32'h00000000;
         default: begin
            if (rd_inbuf)
               nxt_rdata = {24'h000000, in_buf_ff[s_axi_araddr[3:2]]};
            else if (buf_hit(s_axi_araddr, `PSBS_OFS_OUT_BUF))
               nxt_rdata = {24'h000000, out_buf_ff[s_axi_araddr[3:2]]};
            else
               nxt_rresp = `PSBS_RESP_SLVERR;
         end
      endcase
   end

   integer i;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff       <= 1'b0;
         w_got_ff        <= 1'b0;
         bvalid_ff       <= 1'b0;
         bresp_ff        <= `PSBS_RESP_OKAY;
         awaddr_ff       <= 8'h00;
         wdata_ff        <= 32'h00000000;
         wstrb_ff        <= 4'h0;
         rvalid_ff       <= 1'b0;
         rresp_ff        <= `PSBS_RESP_OKAY;
         rdata_ff        <= 32'h00000000;
         slave_mode_ff   <= `PSBS_RST_CTRL;
         in_full_ff      <= `PSBS_RST_IN_FULL;
         out_empty_ff    <= `PSBS_RST_OUT_EMPTY;
         in_ovf_ff       <= `PSBS_RST_ERR;
         out_udf_ff      <= `PSBS_RST_ERR;
         int_stat_ff     <= `PSBS_RST_INT;
         int_en_ff       <= `PSBS_RST_INT;
         host_rd_data_ff <= 8'h00;
         for (i = 0; i < NBUF; i = i + 1) begin
            in_buf_ff[i]  <= 8'h00;
            out_buf_ff[i] <= 8'h00;
         end
      end else begin
         // Write address and data taken in either order
         if (do_wr) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? `PSBS_RESP_OKAY : `PSBS_RESP_SLVERR;
         end else begin
            if (aw_hs) begin
               aw_got_ff <= 1'b1;
               awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
               w_got_ff <= 1'b1;
               wdata_ff <= s_axi_wdata;
               wstrb_ff <= s_axi_wstrb;
            end
            if (bvalid_ff && s_axi_bready)
               bvalid_ff <= 1'b0;
         end
         // Read answer one cycle after the address is taken
         if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
         // Control and interrupt registers
         if (wr_ctrl && ws[0])
            slave_mode_ff <= wd[`PSBS_BIT_SLAVE_MODE];
         if (wr_int_en && ws[0])
            int_en_ff <= wd[3:0];
         int_stat_ff  <= nxt_int_stat;
         // Buffer flags
         in_full_ff   <= nxt_in_full;
         out_empty_ff <= nxt_out_empty;
         in_ovf_ff    <= nxt_in_ovf;
         out_udf_ff   <= nxt_out_udf;
         // Buffer data
         for (i = 0; i < NBUF; i = i + 1) begin
            if (in_take[i])
               in_buf_ff[i] <= wr_dat_s1_ff;
            if (sw_wr_sel[i])
               out_buf_ff[i] <= wd[7:0];
         end
         if (host_rd)
            host_rd_data_ff <= out_buf_ff[rd_idx_s1_ff];
      end
   end

endmodule // psbs_status

`default_nettype wire

/* File: test/psbs_status_asserts.sv */
// Purpose: Port checks for psbs_status
// Assumes: Status word at 0x00, read data one cycle after the address
// Notes:   Bound to every psbs_status instance
`timescale 1ns/1ps
`default_nettype none
module psbs_status_asserts (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register read channel
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Host side and interrupt
   input wire logic        host_rd_req,
   input wire logic [7:0]  host_rd_data,
   input wire logic        irq
);
   logic [7:0] ra_ff;
   logic       st_rd;
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
   end
   assign st_rd = s_axi_rvalid && ra_ff == 8'h00;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_unused_zero;
      st_rd |-> {s_axi_rdata[31:16], s_axi_rdata[13:12], s_axi_rdata[5:4]} == 20'h00000; endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused status bits set");
   property p_all_full; st_rd |-> s_axi_rdata[15] == &s_axi_rdata[11:8]; endproperty
   a_all_full: assert property (p_all_full) else $error("all full flag wrong");
   property p_all_empty; st_rd |-> s_axi_rdata[7] == &s_axi_rdata[3:0]; endproperty
   a_all_empty: assert property (p_all_empty) else $error("all empty flag wrong");
   property p_reset_state; $rose(aresetn) |-> !s_axi_rvalid && !irq && host_rd_data == 8'h00; endproperty
   a_reset_state: assert property (p_reset_state) else $error("outputs not cleared by reset");
   property p_rd_cause;
      !$stable(host_rd_data) |-> $past(host_rd_req, 2) || $past(host_rd_req, 3) || $past(host_rd_req, 4); endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("host data changed without a host read");
   property p_r_latency; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_latency: assert property (p_r_latency) else $error("read answer late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_refuse: assert property (p_ar_refuse) else $error("address taken while answer pending");
endmodule // psbs_status_asserts
bind psbs_status psbs_status_asserts psbs_status_asserts_i (.*);
`default_nettype wire

/* File: test/psbs_host_model.sv */
// Purpose: External host driving the parallel port strobes
// Assumes: Called right after a rising clock edge
// Notes:   Released index and data lines show their inverse
`timescale 1ns/1ps
`default_nettype none
module psbs_host_model (
   // Clock
   input  wire logic       aclk,
   // Host strobes and data
   output var  logic       host_wr_req,
   output var  logic [1:0] host_wr_idx,
   output var  logic [7:0] host_wr_data,
   output var  logic       host_rd_req,
   output var  logic [1:0] host_rd_idx,
   input  wire logic [7:0] host_rd_data
);
   initial begin
      {host_wr_req, host_rd_req, host_wr_idx, host_rd_idx, host_wr_data} = 14'h0000;
   end
   // One access, strobe high six clocks; q returns the byte read
   task automatic xfer(input logic rd, input logic [1:0] i, input logic [7:0] d, output logic [7:0] q);
      @(posedge aclk);
      host_wr_idx <= i;
      host_rd_idx <= i;
      host_wr_data <= d;
      @(posedge aclk);
      host_wr_req <= !rd;
      host_rd_req <= rd;
      repeat (6) @(posedge aclk);
      q = host_rd_data;
      host_wr_req <= 1'b0;
      host_rd_req <= 1'b0;
      repeat (4) @(posedge aclk);
      host_wr_idx <= ~i;
      host_rd_idx <= ~i;
      host_wr_data <= ~d;
   endtask
endmodule // psbs_host_model
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Self-checking bench for psbs_status
// Assumes: 20 MHz aclk, host model on the parallel side
// Notes:   Status, control, interrupt and buffer registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_wr_req, host_rd_req, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, host_wr_data, host_rd_data, q;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, host_wr_idx, host_rd_idx;
   int          bad_count, checks;
   psbs_status psbs_status_i (.*);
   psbs_host_model psbs_host_model_i (.*);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
      logic ah, wh, bh;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(negedge aclk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         if (bh) chk("bresp", er, s_axi_bresp);
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (bh) s_axi_bready <= 1'b0;
      end while (!bh);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ah, rh;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(negedge aclk);
         ah = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         if (rh) chk("rdata", e, s_axi_rdata);
         if (rh) chk("rresp", er, s_axi_rresp);
         @(posedge aclk);
         if (ah) s_axi_arvalid <= 1'b0;
         if (rh) s_axi_rready <= 1'b0;
      end while (!rh);
   endtask
   task automatic finish_test;
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 32'h0, 2'h0);
      wr(8'h04, 32'h1, 4'h1, 2'h0);
      rd(8'h00, 32'h008F, 2'h0);
      for (int i = 0; i < 3; i++) psbs_host_model_i.xfer(1'b0, i[1:0], 8'hA0 + i[7:0], q);
      rd(8'h00, 32'h078F, 2'h0);
      psbs_host_model_i.xfer(1'b0, 2'h3, 8'hA3, q);
      rd(8'h00, 32'h8F8F, 2'h0);
      psbs_host_model_i.xfer(1'b0, 2'h2, 8'h55, q);
      rd(8'h00, 32'hCF8F, 2'h0);
      rd(8'h28, 32'hA2, 2'h0);
      rd(8'h00, 32'h4B8F, 2'h0);
      rd(8'h00, 32'h4B8F, 2'h0);
      wr(8'h00, 32'hFFFFFFFF, 4'hF, 2'h0);
      rd(8'h00, 32'h4B8F, 2'h0);
      wr(8'h00, 32'h0, 4'h2, 2'h0);
      rd(8'h00, 32'h0B8F, 2'h0);
      wr(8'h34, 32'h3C, 4'h1, 2'h0);
      rd(8'h00, 32'h0B0D, 2'h0);
      rd(8'h34, 32'h3C, 2'h0);
      psbs_host_model_i.xfer(1'b1, 2'h1, 8'h00, q);
      chk("host_rd_data", 32'h3C, {24'h0, q});
      rd(8'h00, 32'h0B8F, 2'h0);
      psbs_host_model_i.xfer(1'b1, 2'h3, 8'h00, q);
      rd(8'h00, 32'h0BCF, 2'h0);
      wr(8'h00, 32'h0, 4'h1, 2'h0);
      rd(8'h00, 32'h0B8F, 2'h0);
      rd(8'h08, 32'hF, 2'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h0C, 32'h8, 4'h1, 2'h0);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h0C, 32'h0, 4'h1, 2'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h10, 32'hF, 4'h1, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      wr(8'h08, 32'hF, 4'h1, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      wr(8'h0C, 32'h1, 4'h1, 2'h0);
      psbs_host_model_i.xfer(1'b0, 2'h2, 8'h66, q);
      chk("irq", 32'h1, {31'h0, irq});
      rd(8'h00, 32'h8F8F, 2'h0);
      rd(8'h40, 32'h0, 2'h2);
      wr(8'h40, 32'h1, 4'hF, 2'h2);
      wr(8'h04, 32'h0, 4'h1, 2'h0);
      rd(8'h00, 32'h0, 2'h0);
      psbs_host_model_i.xfer(1'b0, 2'h0, 8'h77, q);
      wr(8'h04, 32'h1, 4'h1, 2'h0);
      rd(8'h00, 32'h8F8F, 2'h0);
      rd(8'h20, 32'hA0, 2'h0);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      finish_test();
   end
endmodule // testbench
`default_nettype wire
